// ==== core/ber_gating_regs.svh ====
`ifndef BER_GATING_REGS_SVH
`define BER_GATING_REGS_SVH
`define REG_CONTROL         8'h00
`define REG_MODE            8'h04
`define REG_PERIOD_SECONDS  8'h08
`define REG_SYNC_CONFIG     8'h0C
`define REG_STATUS          8'h10
`define REG_ELAPSED         8'h14
`define REG_POWER_LOSS_SEC  8'h18
`define REG_ERROR_COUNT     8'h1C
`define REG_REPORT_ERRORS   8'h20
`define REG_BITS_LO         8'h24
`define CTRL_RUN_BIT        0
`define CTRL_STOP_BIT       1
`define CTRL_RESYNC_BIT     2
`define CTRL_POWER_BACK_BIT 3
`define MAX_PERIOD_SECONDS  32'd8553600
`define MIN_PERIOD_SECONDS  32'd1
`define POWER_SYNC_WAIT_S   8'd25
`define ONE_SECOND_NS       64'd1000000000
`define CLK_PERIOD_NS       64'd20
`define MODE_RESET          32'h0000_0012
`define SYNC_RESET          32'h0000_0011
`define PATTERN_LEN         16
`endif

// ==== core/ber_gating_pkg.sv ====
package ber_gating_pkg;
    typedef enum logic [1:0] {
        GATE_USER   = 2'd0,
        GATE_SINGLE = 2'd1,
        GATE_REPEAT = 2'd2
    } gate_mode_t;
    typedef enum logic [1:0] {
        BOUND_TIME  = 2'd0,
        BOUND_ERROR = 2'd1,
        BOUND_BITS  = 2'd2
    } bound_t;
endpackage

// ==== core/ber_gating_sync_control.sv ====
// How it works
// R1: one period mode active, others deselected
// R2: after power back, resync 25 s; here the wait runs only with master_slave_cfg and auto resync set
// R3: no sync after 25 s, force start
// R4: power-loss seconds count unmeasured time
// R5: mode and length locked while gating
// R6: run restarts period; stop ends it
// R7: single stops itself; user runs till stop
// R8: repeat restarts on same cycle
// R9: user mode allows time bound only
// R10: time length 1 s to 99 days
// R11: error limits 10, 100, 1000 only
// R12: bit limits 1E7 to 1E15 decades
// R13: time period ends at selected duration
// R14: bound choices exclusive, locked while gating
// R15: report selector effective in repeat only
// R16: locked only while errors below limit
// R17: auto mode resyncs itself, manual waits
// R18: resync request starts search at once
// R19: lock limit 1e-01 to 1e-08 decades
// R20: try all alignments, flag fail, retry
// R21: expose lock limit and sync mode
// R22: time from free one-second tick
// R23: accumulators clear at each period start
`timescale 1ns/1ps
`include "ber_gating_regs.svh"
module ber_gating_sync_control
    import ber_gating_pkg::*;
#(
    parameter int WINDOW_BITS = 1000,
    parameter int PATTERN_W   = `PATTERN_LEN
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        link_clk,
    input  wire logic        link_data,
    input  wire logic        master_slave_cfg,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    output logic             gating,
    output logic             period_end,
    output logic             in_sync,
    output logic             sync_searching,
    output logic             sync_failed
);
    localparam logic [31:0] TICK_CYCLES = 32'(`ONE_SECOND_NS / `CLK_PERIOD_NS);
    localparam logic [15:0] WIN_BITS    = 16'(WINDOW_BITS);

    function automatic logic [63:0] pow10(input logic [3:0] e);
        logic [63:0] v;
        v = 64'h1;
        for (int i = 0; i < 15; i++) begin
            if (4'(i) < e) begin
                v = v * 64'd10;
            end
        end
        return v;
    endfunction

    // synchronisers
    logic [2:0] lclk_q, lclk_d;
    logic [1:0] ldat_q, ldat_d;
    logic [1:0] ms_q, ms_d;
    always_comb begin
        lclk_d = {lclk_q[1:0], link_clk};
        ldat_d = {ldat_q[0], link_data};
        ms_d   = {ms_q[0], master_slave_cfg};
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lclk_q <= 3'h0;
            ldat_q <= 2'h0;
            ms_q   <= 2'h0;
        end else begin
            lclk_q <= lclk_d;
            ldat_q <= ldat_d;
            ms_q   <= ms_d;
        end
    end
    logic bit_strobe;
    assign bit_strobe = lclk_q[1] & ~lclk_q[2];

    // configuration state
    gate_mode_t  mode_q, mode_d;
    bound_t      bound_q, bound_d;
    logic [31:0] period_s_q, period_s_d;
    logic [1:0]  err_sel_q, err_sel_d;
    logic [3:0]  bit_exp_q, bit_exp_d;
    logic        report_prev_q, report_prev_d;
    logic        resync_auto_q, resync_auto_d;
    logic [3:0]  lock_exp_q, lock_exp_d;
    logic        refused_q, refused_d;
    logic        cfg_wr;
    assign cfg_wr = wr & ((addr == `REG_MODE) | (addr == `REG_PERIOD_SECONDS));

    always_comb begin
        mode_d        = mode_q;
        bound_d       = bound_q;
        period_s_d    = period_s_q;
        err_sel_d     = err_sel_q;
        bit_exp_d     = bit_exp_q;
        report_prev_d = report_prev_q;
        resync_auto_d = resync_auto_q;
        lock_exp_d    = lock_exp_q;
        refused_d     = refused_q;
        if (wr && addr == `REG_STATUS) begin
            refused_d = 1'b0;
        end
        if (cfg_wr && gating) begin
            refused_d = 1'b1; // [R5] [R14]
        end else if (wr && addr == `REG_MODE) begin
            if (wdata[1:0] <= 2'd2) begin
                mode_d = gate_mode_t'(wdata[1:0]); // [R1]
            end
            if (wdata[1:0] == 2'd0) begin
                bound_d = BOUND_TIME; // [R9]
            end else if (wdata[3:2] <= 2'd2) begin
                bound_d = bound_t'(wdata[3:2]); // [R14]
            end
            if (wdata[5:4] <= 2'd2) begin
                err_sel_d = wdata[5:4]; // [R11]
            end
            if (wdata[11:8] >= 4'd7 && wdata[11:8] <= 4'd15) begin
                bit_exp_d = wdata[11:8]; // [R12]
            end
        end else if (wr && addr == `REG_PERIOD_SECONDS) begin
            if (wdata >= `MIN_PERIOD_SECONDS && wdata <= `MAX_PERIOD_SECONDS) begin
                period_s_d = wdata; // [R10]
            end else begin
                refused_d = 1'b1;
            end
        end
        if (wr && addr == `REG_MODE) begin
            report_prev_d = wdata[12];
        end
        if (wr && addr == `REG_SYNC_CONFIG) begin
            resync_auto_d = wdata[0];
            if (wdata[7:4] >= 4'd1 && wdata[7:4] <= 4'd8) begin
                lock_exp_d = wdata[7:4]; // [R19]
            end
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_q        <= GATE_USER;
            bound_q       <= BOUND_TIME;
            period_s_q    <= 32'd60;
            err_sel_q     <= 2'd0;
            bit_exp_q     <= 4'd7;
            report_prev_q <= 1'b0;
            resync_auto_q <= 1'b1;
            lock_exp_q    <= 4'd3;
            refused_q     <= 1'b0;
        end else begin
            mode_q        <= mode_d;
            bound_q       <= bound_d;
            period_s_q    <= period_s_d;
            err_sel_q     <= err_sel_d;
            bit_exp_q     <= bit_exp_d;
            report_prev_q <= report_prev_d;
            resync_auto_q <= resync_auto_d;
            lock_exp_q    <= lock_exp_d;
            refused_q     <= refused_d;
        end
    end

    // pattern checker and sync search
    logic [PATTERN_W-1:0] ref_q, ref_d;
    logic [15:0] shift_q, shift_d;
    logic [15:0] win_bits_q, win_bits_d;
    logic [15:0] win_err_q, win_err_d;
    logic        in_sync_q, in_sync_d;
    logic        search_q, search_d;
    logic        failed_q, failed_d;
    logic        bit_err;
    logic        resync_req;
    logic [31:0] limit_errs;
    assign bit_err    = bit_strobe & (ldat_q[1] ^ ref_q[PATTERN_W-1]);
    assign resync_req = wr & (addr == `REG_CONTROL) & wdata[`CTRL_RESYNC_BIT];
    // error count allowed per window; tighter limits than the window resolves read as zero errors
    assign limit_errs = 32'(WINDOW_BITS) / 32'(pow10(lock_exp_q));

    always_comb begin
        ref_d      = ref_q;
        shift_d    = shift_q;
        win_bits_d = win_bits_q;
        win_err_d  = win_err_q;
        in_sync_d  = in_sync_q;
        search_d   = search_q;
        failed_d   = failed_q;
        if (bit_strobe) begin
            ref_d      = {ref_q[PATTERN_W-2:0], ref_q[PATTERN_W-1] ^ ref_q[PATTERN_W-2]};
            win_bits_d = win_bits_q + 16'd1;
            win_err_d  = win_err_q + {15'd0, bit_err};
            if (win_bits_q == WIN_BITS - 16'd1) begin
                win_bits_d = 16'd0;
                if (32'(win_err_d) < limit_errs || (limit_errs == 32'd0 && win_err_d == 16'd0)) begin
                    in_sync_d = 1'b1; // [R16]
                    search_d  = 1'b0;
                end else begin
                    in_sync_d = 1'b0; // [R16]
                    if (search_q) begin
                        // slip one bit to try the next alignment
                        ref_d   = ref_q;
                        shift_d = shift_q + 16'd1; // [R20]
                        if (shift_q == 16'(PATTERN_W - 1)) begin
                            shift_d  = 16'd0;
                            failed_d = 1'b1; // [R20]
                        end
                    end else if (resync_auto_q) begin
                        search_d = 1'b1; // [R17]
                    end
                end
                // window judged first, then cleared for the next one
                win_err_d = 16'd0;
            end
        end
        if (in_sync_d) begin
            failed_d = 1'b0;
        end
        if (resync_req) begin
            search_d   = 1'b1; // [R18]
            in_sync_d  = 1'b0;
            shift_d    = 16'd0;
            win_bits_d = 16'd0;
            win_err_d  = 16'd0;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ref_q      <= {{(PATTERN_W-1){1'b0}}, 1'b1};
            shift_q    <= 16'd0;
            win_bits_q <= 16'd0;
            win_err_q  <= 16'd0;
            in_sync_q  <= 1'b0;
            search_q   <= 1'b1;
            failed_q   <= 1'b0;
        end else begin
            ref_q      <= ref_d;
            shift_q    <= shift_d;
            win_bits_q <= win_bits_d;
            win_err_q  <= win_err_d;
            in_sync_q  <= in_sync_d;
            search_q   <= search_d;
            failed_q   <= failed_d;
        end
    end

    // one-second tick, independent of the link clock
    logic [31:0] tick_cnt_q, tick_cnt_d;
    logic        tick;
    assign tick = (tick_cnt_q == TICK_CYCLES - 32'd1);
    always_comb begin
        tick_cnt_d = tick ? 32'd0 : tick_cnt_q + 32'd1; // [R22]
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_q <= 32'd0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    // gating control
    logic        gating_q, gating_d;
    logic        end_q, end_d;
    logic [31:0] elapsed_q, elapsed_d;
    logic [31:0] errs_q, errs_d;
    logic [63:0] bits_q, bits_d;
    logic [31:0] prev_errs_q, prev_errs_d;
    logic        pwr_wait_q, pwr_wait_d;
    logic [7:0]  pwr_s_q, pwr_s_d;
    logic [31:0] lost_s_q, lost_s_d;
    logic        run_cmd, stop_cmd, power_back, limit_hit, start;
    logic [31:0] err_limit;
    assign run_cmd    = wr & (addr == `REG_CONTROL) & wdata[`CTRL_RUN_BIT];
    assign stop_cmd   = wr & (addr == `REG_CONTROL) & wdata[`CTRL_STOP_BIT];
    assign power_back = wr & (addr == `REG_CONTROL) & wdata[`CTRL_POWER_BACK_BIT];
    assign err_limit  = 32'(pow10({2'd0, err_sel_q} + 4'd1));

    always_comb begin
        unique case (bound_q)
            BOUND_TIME:  limit_hit = tick && (elapsed_q + 32'd1 >= period_s_q); // [R13]
            BOUND_ERROR: limit_hit = errs_q + {31'd0, bit_err} >= err_limit; // [R11]
            BOUND_BITS:  limit_hit = bits_q + {63'd0, bit_strobe} >= pow10(bit_exp_q); // [R12]
            default:     limit_hit = 1'b0;
        endcase
        if (mode_q == GATE_USER) begin
            limit_hit = 1'b0; // [R7]
        end
    end

    always_comb begin
        gating_d    = gating_q;
        end_d       = 1'b0;
        elapsed_d   = elapsed_q;
        errs_d      = errs_q;
        bits_d      = bits_q;
        prev_errs_d = prev_errs_q;
        pwr_wait_d  = pwr_wait_q;
        pwr_s_d     = pwr_s_q;
        lost_s_d    = lost_s_q;
        start       = 1'b0;
        if (gating_q) begin
            errs_d = errs_q + {31'd0, bit_err};
            bits_d = bits_q + {63'd0, bit_strobe};
            if (tick) begin
                elapsed_d = elapsed_q + 32'd1;
            end
            if (limit_hit) begin
                end_d       = 1'b1;
                prev_errs_d = errs_d;
                gating_d    = (mode_q == GATE_REPEAT); // [R7] [R8]
                start       = (mode_q == GATE_REPEAT); // [R8]
            end
        end
        if (pwr_wait_q) begin
            if (tick) begin
                pwr_s_d  = pwr_s_q + 8'd1;
                lost_s_d = lost_s_q + 32'd1; // [R4]
            end
            if (in_sync_q) begin
                pwr_wait_d = 1'b0;
                gating_d   = 1'b1; // [R2]
                start      = 1'b1;
            end else if (tick && pwr_s_q + 8'd1 >= `POWER_SYNC_WAIT_S) begin
                pwr_wait_d = 1'b0;
                gating_d   = 1'b1; // [R3]
                start      = 1'b1;
            end
        end
        if (power_back) begin
            // power loss ends any running period; the wait above resumes it only with master_slave_cfg and auto resync set
            lost_s_d   = lost_s_q + 32'd1; // [R4]
            gating_d   = 1'b0;
            end_d      = gating_q;
            pwr_s_d    = 8'd0;
            pwr_wait_d = ms_q[1] & resync_auto_q; // [R2]
        end
        if (stop_cmd) begin
            gating_d   = 1'b0; // [R6]
            pwr_wait_d = 1'b0;
            start      = 1'b0;
            end_d      = gating_q;
        end
        if (run_cmd) begin
            gating_d   = 1'b1; // [R6]
            pwr_wait_d = 1'b0;
            start      = 1'b1;
            end_d      = gating_q;
            if (!pwr_wait_q && !power_back) begin
                lost_s_d = 32'd0;
            end
        end
        if (start) begin
            elapsed_d = 32'd0; // [R23]
            errs_d    = 32'd0;
            bits_d    = 64'd0;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gating_q    <= 1'b0;
            end_q       <= 1'b0;
            elapsed_q   <= 32'd0;
            errs_q      <= 32'd0;
            bits_q      <= 64'd0;
            prev_errs_q <= 32'd0;
            pwr_wait_q  <= 1'b0;
            pwr_s_q     <= 8'd0;
            lost_s_q    <= 32'd0;
        end else begin
            gating_q    <= gating_d;
            end_q       <= end_d;
            elapsed_q   <= elapsed_d;
            errs_q      <= errs_d;
            bits_q      <= bits_d;
            prev_errs_q <= prev_errs_d;
            pwr_wait_q  <= pwr_wait_d;
            pwr_s_q     <= pwr_s_d;
            lost_s_q    <= lost_s_d;
        end
    end

    // read port
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] report_val;
    assign report_val = (mode_q == GATE_REPEAT && report_prev_q) ? prev_errs_q : errs_q; // [R15]
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rd) begin
            unique case (addr)
                `REG_MODE:           rdata_d = {19'd0, report_prev_q, bit_exp_q, 2'd0, err_sel_q,
                                                bound_q, mode_q};
                `REG_PERIOD_SECONDS: rdata_d = period_s_q;
                `REG_SYNC_CONFIG:    rdata_d = {24'd0, lock_exp_q, 3'd0, resync_auto_q}; // [R21]
                `REG_STATUS:         rdata_d = {26'd0, pwr_wait_q, refused_q, failed_q, search_q,
                                                in_sync_q, gating_q};
                `REG_ELAPSED:        rdata_d = elapsed_q;
                `REG_POWER_LOSS_SEC: rdata_d = lost_s_q; // [R4]
                `REG_ERROR_COUNT:    rdata_d = errs_q;
                `REG_REPORT_ERRORS:  rdata_d = report_val;
                `REG_BITS_LO:        rdata_d = bits_q[31:0];
                default:             rdata_d = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata          = rdata_q;
    assign gating         = gating_q;
    assign period_end     = end_q;
    assign in_sync        = in_sync_q;
    assign sync_searching = search_q;
    assign sync_failed    = failed_q;
endmodule

// ==== verification/ber_gating_props_properties.sv ====
`timescale 1ns/1ps
module ber_gating_props
    import ber_gating_pkg::*;
#(
    parameter int WINDOW_BITS = 1000
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        link_clk,
    input wire logic        link_data,
    input wire logic        master_slave_cfg,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        gating,
    input wire logic        period_end,
    input wire logic        in_sync,
    input wire logic        sync_searching,
    input wire logic        sync_failed
);
    gate_mode_t mode_q;
    gate_mode_t mode_d;
    logic       run_wr;
    logic       stop_wr;
    logic       resync_wr;
    assign run_wr    = wr && addr == 8'h00 && wdata[0] && !wdata[1];
    assign stop_wr   = wr && addr == 8'h00 && wdata[1] && !wdata[0];
    assign resync_wr = wr && addr == 8'h00 && wdata[2];
    // mirror of the mode field; writes while gating are refused
    always_comb begin
        mode_d = mode_q;
        if (wr && addr == 8'h04 && !gating && wdata[1:0] != 2'h3) begin
            mode_d = gate_mode_t'(wdata[1:0]);
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= GATE_USER;
        end else begin
            mode_q <= mode_d;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_run_start;
        run_wr && !gating |=> gating;
    endproperty
    a_run_start: assert property (p_run_start) else $error("run did not start gating");
    property p_restart;
        run_wr && gating |=> gating && period_end;
    endproperty
    a_restart: assert property (p_restart) else $error("run while gating did not restart");
    property p_stop;
        stop_wr && gating |=> !gating && period_end;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not end gating");
    property p_single;
        period_end && mode_q == GATE_SINGLE && !$past(run_wr) |-> !gating;
    endproperty
    a_single: assert property (p_single) else $error("single period did not stop");
    property p_repeat;
        period_end && mode_q == GATE_REPEAT && !$past(stop_wr) |-> gating;
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeat period left dead time");
    property p_fall_end;
        $fell(gating) |-> period_end;
    endproperty
    a_fall_end: assert property (p_fall_end) else $error("gating fell without period end");
    property p_resync;
        resync_wr |=> sync_searching && !in_sync;
    endproperty
    a_resync: assert property (p_resync) else $error("resync request ignored");
    property p_lock_excl;
        in_sync |-> !sync_searching && !sync_failed;
    endproperty
    a_lock_excl: assert property (p_lock_excl) else $error("lock shown while searching");
    c_repeat_end: cover property (period_end && gating);
    c_fell: cover property ($fell(gating));
    c_failed: cover property ($rose(sync_failed));
endmodule
bind ber_gating_sync_control ber_gating_props #(.WINDOW_BITS(WINDOW_BITS)) ber_gating_props_i (
    .clk(clk), .rstn(rstn), .link_clk(link_clk), .link_data(link_data),
    .master_slave_cfg(master_slave_cfg), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .gating(gating), .period_end(period_end), .in_sync(in_sync),
    .sync_searching(sync_searching), .sync_failed(sync_failed));

// ==== verification/link_source.sv ====
`timescale 1ns/1ps
module link_source (
    input  wire logic en,
    input  wire logic level,
    output logic      link_clk,
    output logic      link_data
);
    initial begin
        link_clk  = 1'b0;
        link_data = 1'b0;
    end
    // bit clock only while enabled; idle data wanders so no stale level is trusted
    always begin
        #80;
        if (en) begin
            link_clk = ~link_clk;
            if (!link_clk) begin
                link_data = level;
            end
        end else begin
            link_clk  = 1'b0;
            link_data = ~link_data;
        end
    end
endmodule

// ==== verification/ber_gating_sync_control_tb.sv ====
`timescale 1ns/1ps
`include "ber_gating_regs.svh"
module ber_gating_sync_control_tb;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] e;} row_t;
    logic        clk, rstn, link_clk, link_data, ms, en, lvl, wr, rd;
    logic        gating, period_end, in_sync, sync_searching, sync_failed;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, v;
    int          n_errors, compares;
    row_t        rows [15] = '{
        '{8'h04, 32'h0000_0004, 32'h0000_000F, 32'h0000_0000},
        '{8'h04, 32'h0000_0025, 32'h0000_003F, 32'h0000_0025},
        '{8'h04, 32'h0000_0035, 32'h0000_003F, 32'h0000_0025},
        '{8'h04, 32'h0000_0F25, 32'h0000_0F3F, 32'h0000_0F25},
        '{8'h04, 32'h0000_0625, 32'h0000_0F3F, 32'h0000_0F25},
        '{8'h04, 32'h0000_0F27, 32'h0000_0F3F, 32'h0000_0F25},
        '{8'h04, 32'h0000_1F26, 32'h0000_1F3F, 32'h0000_1F26},
        '{8'h08, 32'h0082_8480, 32'hFFFF_FFFF, 32'h0082_8480},
        '{8'h08, 32'h0082_8481, 32'hFFFF_FFFF, 32'h0082_8480},
        '{8'h08, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0082_8480},
        '{8'h08, 32'h0000_0001, 32'hFFFF_FFFF, 32'h0000_0001},
        '{8'h0C, 32'h0000_0081, 32'h0000_00F1, 32'h0000_0081},
        '{8'h0C, 32'h0000_0090, 32'h0000_00F1, 32'h0000_0080},
        '{8'h0C, 32'h0000_0001, 32'h0000_00F1, 32'h0000_0081},
        '{8'hFC, 32'h0000_FFFF, 32'hFFFF_FFFF, 32'h0000_0000}};
    ber_gating_sync_control #(.WINDOW_BITS(20)) ber_gating_sync_control_i (
        .clk(clk), .rstn(rstn), .link_clk(link_clk), .link_data(link_data), .master_slave_cfg(ms),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gating(gating),
        .period_end(period_end), .in_sync(in_sync), .sync_searching(sync_searching),
        .sync_failed(sync_failed));
    link_source link_source_i (.en(en), .level(lvl), .link_clk(link_clk), .link_data(link_data));
    always #10 clk = ~clk;
    task automatic wrap_up();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask
    // bounded wait on period end or search failure
    task automatic wait_hi(input bit sel_fail, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge clk);
            #1;
            if ((sel_fail ? sync_failed : period_end) === 1'b1) return;
        end
        check("wait", 32'h0, 32'h1);
        wrap_up();
    endtask
    initial begin
        clk = 1'b0; rstn = 1'b0; ms = 1'b0; en = 1'b0; lvl = 1'b1; wr = 1'b0; rd = 1'b0;
        addr = 8'h00; wdata = 32'h0; n_errors = 0; compares = 0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        check("gating", {31'h0, gating}, 32'h0);
        check("searching", {31'h0, sync_searching}, 32'h1);
        rd_reg(`REG_PERIOD_SECONDS, v);
        check("period", v, 32'h0000_003C);
        $display("test reset done");
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a, v);
            check("table", v & rows[i].m, rows[i].e);
        end
        $display("test table done");
        en <= 1'b1;
        wr_reg(`REG_MODE, 32'h0000_0005);
        wr_reg(`REG_CONTROL, 32'h0000_0001);
        check("gating", {31'h0, gating}, 32'h1);
        wait_hi(1'b0, 5000);
        check("gating", {31'h0, gating}, 32'h0);
        rd_reg(`REG_ERROR_COUNT, v);
        check("errors", v, 32'h0000_000A);
        $display("test single done");
        wr_reg(`REG_MODE, 32'h0000_0000);
        wr_reg(`REG_STATUS, 32'h0000_0000);
        wr_reg(`REG_CONTROL, 32'h0000_0001);
        wr_reg(`REG_MODE, 32'h0000_0006);
        wr_reg(`REG_PERIOD_SECONDS, 32'h0000_0005);
        rd_reg(`REG_MODE, v);
        check("mode", v & 32'h0000_000F, 32'h0000_0000);
        rd_reg(`REG_PERIOD_SECONDS, v);
        check("period", v, 32'h0000_0001);
        rd_reg(`REG_STATUS, v);
        check("refused", v & 32'h0000_0011, 32'h0000_0011);
        wr_reg(`REG_CONTROL, 32'h0000_0001);
        check("gating", {31'h0, gating}, 32'h1);
        wr_reg(`REG_CONTROL, 32'h0000_0002);
        check("gating", {31'h0, gating}, 32'h0);
        $display("test refuse done");
        wr_reg(`REG_MODE, 32'h0000_1006);
        wr_reg(`REG_CONTROL, 32'h0000_0001);
        repeat (2) begin
            wait_hi(1'b0, 5000);
            check("gating", {31'h0, gating}, 32'h1);
        end
        rd_reg(`REG_REPORT_ERRORS, v);
        check("report", v, 32'h0000_000A);
        wr_reg(`REG_CONTROL, 32'h0000_0002);
        en <= 1'b0;
        repeat (20) @(posedge clk);
        wr_reg(`REG_CONTROL, 32'h0000_0001);
        rd_reg(`REG_ERROR_COUNT, v);
        check("errors", v, 32'h0000_0000);
        rd_reg(`REG_BITS_LO, v);
        check("bits", v, 32'h0000_0000);
        wr_reg(`REG_CONTROL, 32'h0000_0002);
        $display("test repeat done");
        en <= 1'b1;
        wr_reg(`REG_CONTROL, 32'h0000_0004);
        check("searching", {31'h0, sync_searching}, 32'h1);
        wait_hi(1'b1, 20000);
        check("in_sync", {31'h0, in_sync}, 32'h0);
        $display("test resync done");
        ms <= 1'b1;
        en <= 1'b0;
        // strap passes the pin synchroniser before power return is signalled
        repeat (3) @(posedge clk);
        wr_reg(`REG_CONTROL, 32'h0000_0008);
        rd_reg(`REG_STATUS, v);
        check("power wait", v & 32'h0000_0021, 32'h0000_0020);
        rd_reg(`REG_POWER_LOSS_SEC, v);
        check("power loss", v, 32'h0000_0001);
        $display("test power done");
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        check("searching", {31'h0, sync_searching}, 32'h1);
        rd_reg(`REG_STATUS, v);
        check("status", v & 32'h0000_0021, 32'h0000_0000);
        $display("test reset again done");
        wrap_up();
    end
endmodule
